// >>> hw/ppfs_pixel_port.sv
// Pixel port with serialiser, palette, clocks, line gate and composite blank
// How it works
// - Frame idle flag is high in frame flyback, low during active display.
// - Frame flag changes on serial rising edges around the frame's shift falls.
// - Line gate changes on serial rising edges around each line's shift falls.
// - Line gate timing ignores pixel depth, always behaves as at 8 bits.
// - Composite blank follows line gate, delayed by the control-bit dependent n.
// - Interlaced: first blank fall of even field delayed by m more serial cycles.
// - One control bit picks palette mode 1 or direct mode 2.
// - Clock source from wiring option and boot bit; PLL only in mode 1.
// - Mode 1 8-bit: four lanes latched per shift fall, shown A,B,C,D.
// - Multiplex ratio follows pixel depth, up to 32 pixels per word.
// - Shift clock pulses once per pixel group, stopped only in line flyback (line_active_in low).
// - Serial clock free-runs at dot rate over four, aligned to shift edges.
// - Shift clock rate is dot rate times depth over 32.
// - Mode 1 palette index is ANDed with the pixel mask register.
// - At 1, 2, 4 bits each field is shifted to the low end and masked.
// - Little-endian: lowest bits of lane A are shown first.
// - Depth code 00,01,10,11 selects 1,2,4,8 bits per pixel.
// - Palette of 256 colour words read and written one word per cycle.
// - Mode 2 latches one 24-bit pixel per clock, lanes A,B,C to R,G,B.
`timescale 1ns/100ps
module ppfs_pixel_port
    import ppfs_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                sys_clk_in,
    input  wire logic                sys_rst_in,
    input  wire logic                clk_en_in,
    // Control bits
    input  wire logic                port_mode_in,
    input  wire logic [1:0]          depth_sel_in,
    input  wire logic [3:0]          blank_dly_bits_in,
    input  wire logic                interlace_in,
    input  wire logic                clk_wiring_pll_in,
    input  wire logic                boot_pll_bit_in,
    // Timing generator
    input  wire logic                line_active_in,
    input  wire logic                frame_active_in,
    input  wire logic                even_field_in,
    input  wire logic [EXT_W-3:0]    even_field_delay_in,
    // Pixel lanes
    input  wire logic [LANE_W-1:0]   pixel_lane_a_in,
    input  wire logic [LANE_W-1:0]   pixel_lane_b_in,
    input  wire logic [LANE_W-1:0]   pixel_lane_c_in,
    input  wire logic [LANE_W-1:0]   pixel_lane_d_in,
    // Mask register on the host bus low byte
    input  wire logic                mask_wr_in,
    input  wire logic [7:0]          host_bus_low_byte_in,
    output logic [7:0]               pixel_address_mask_out,
    // Colour palette host port
    input  wire logic                pal_wr_in,
    input  wire logic                pal_rd_in,
    input  wire logic [7:0]          pal_addr_in,
    input  wire logic [COLOUR_W-1:0] pal_wdata_in,
    output logic [COLOUR_W-1:0]      pal_rdata_out,
    // Video side
    output logic                     free_serial_clock_n_out,
    output logic                     vram_shift_clock_n_out,
    output logic                     frame_idle_flag_out,
    output logic                     line_clock_gate_out,
    output logic                     composite_blank_out,
    output logic                     use_pll_out,
    output logic [7:0]               pixel_index_out,
    output logic [COLOUR_W-1:0]      pixel_colour_out,
    output logic                     pixel_valid_out
);
    logic [1:0]          phase_q;
    logic [1:0]          phase_d;
    logic [2:0]          grp_q;
    logic [2:0]          grp_last;
    logic                shift_en_q;
    logic                latch_now;
    logic [WORD_W-1:0]   sreg_q;
    logic [5:0]          dots_q;
    logic                busy_q;
    logic [7:0]          field;
    logic [7:0]          depth_mask;
    logic [7:0]          mask_q;
    logic [COLOUR_W-1:0] palette [PAL_DEPTH];
    logic [DLY_LEN-1:0]  dly_q;
    logic [5:0]          tap;
    logic                blank_raw;
    logic [EXT_W-1:0]    ext_q;
    logic                ext_pend_q;

    assign phase_d   = phase_q + 2'h1;
    assign latch_now = clk_en_in && shift_en_q && (phase_d == PH_FALL);

    // Depth decode: serial periods per group minus one, and field mask
    always_comb begin
        unique case (depth_sel_in)
            BPP_1: begin grp_last = 3'h7; depth_mask = 8'h01; field = {7'h00, sreg_q[0]}; end
            BPP_2: begin grp_last = 3'h3; depth_mask = 8'h03; field = {6'h00, sreg_q[1:0]}; end
            BPP_4: begin grp_last = 3'h1; depth_mask = 8'h0F; field = {4'h0, sreg_q[3:0]}; end
            BPP_8: begin grp_last = 3'h0; depth_mask = 8'hFF; field = sreg_q[7:0]; end
        endcase
    end

    // Free-running serial clock, high in phases 0 and 1
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            phase_q                 <= PH_LAST;
            free_serial_clock_n_out <= 1'h0;
        end else if (clk_en_in) begin
            phase_q                 <= phase_d;
            free_serial_clock_n_out <= !phase_d[1];
        end
    end

    // Group counter and the two gates moved on serial rising edges, shift clock low in phases 2 and 3
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            grp_q                  <= 3'h0;
            shift_en_q             <= 1'h0;
            vram_shift_clock_n_out <= 1'h1;
            line_clock_gate_out    <= 1'h1;
            frame_idle_flag_out    <= 1'h1;
        end else if (clk_en_in) begin
            if (phase_d == PH_RISE) begin
                line_clock_gate_out <= !line_active_in;
                frame_idle_flag_out <= !frame_active_in;
                if (line_active_in) begin
                    shift_en_q <= (grp_q == 3'h0);
                    grp_q      <= (grp_q == grp_last) ? 3'h0 : grp_q + 3'h1;
                end else begin
                    shift_en_q <= 1'h0;
                    grp_q      <= 3'h0;
                end
            end
            vram_shift_clock_n_out <= !(phase_d[1] && shift_en_q);
        end
    end

    // Serialiser: load word on shift fall, shift out one field per dot
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            sreg_q <= '0;
            dots_q <= 6'h00;
            busy_q <= 1'h0;
        end else if (latch_now) begin
            sreg_q <= {pixel_lane_d_in, pixel_lane_c_in,
                       pixel_lane_b_in, pixel_lane_a_in};
            dots_q <= {1'h0, grp_last, 2'h3};
            busy_q <= 1'h1;
        end else if (clk_en_in && busy_q) begin
            unique case (depth_sel_in)
                BPP_1: sreg_q <= {1'h0, sreg_q[WORD_W-1:1]};
                BPP_2: sreg_q <= {2'h0, sreg_q[WORD_W-1:2]};
                BPP_4: sreg_q <= {4'h0, sreg_q[WORD_W-1:4]};
                BPP_8: sreg_q <= {8'h00, sreg_q[WORD_W-1:8]};
            endcase
            dots_q <= dots_q - 6'h01;
            busy_q <= (dots_q != 6'h00);
        end
    end

    // Mask register on the host bus low byte
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            mask_q <= MASK_RESET;
        end else if (clk_en_in && mask_wr_in) begin
            mask_q <= host_bus_low_byte_in;
        end
    end
    assign pixel_address_mask_out = mask_q;

    // Palette storage and host access
    always_ff @(posedge sys_clk_in) begin
        if (clk_en_in && pal_wr_in) begin
            palette[pal_addr_in] <= pal_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pal_rdata_out <= '0;
        end else if (clk_en_in && pal_rd_in) begin
            pal_rdata_out <= palette[pal_addr_in];
        end
    end

    // Pixel output: palette lookup in mode 1, direct in mode 2
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pixel_index_out  <= 8'h00;
            pixel_colour_out <= '0;
            pixel_valid_out  <= 1'h0;
        end else if (clk_en_in) begin
            if (port_mode_in == MODE_DIRECT) begin
                pixel_index_out  <= 8'h00;
                pixel_colour_out <= {pixel_lane_a_in, pixel_lane_b_in, pixel_lane_c_in};
                pixel_valid_out  <= 1'h1;
            end else begin
                pixel_index_out  <= field & depth_mask & mask_q;
                pixel_colour_out <= palette[field & depth_mask & mask_q];
                pixel_valid_out  <= busy_q;
            end
        end
    end

    // PLL only when wired for it, booted for it and in mode 1
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            use_pll_out <= 1'h0;
        end else if (clk_en_in) begin
            use_pll_out <= clk_wiring_pll_in && boot_pll_bit_in
                           && (port_mode_in == MODE_PALETTE);
        end
    end

    // Composite blank: line gate delayed by n serial cycles, in dots
    always_comb begin
        tap = BLANK_BASE
              - (blank_dly_bits_in[0] ? BLANK_B8 : 6'h00)
              + (blank_dly_bits_in[1] ? BLANK_B9 : 6'h00)
              + (blank_dly_bits_in[2] ? BLANK_B10 : 6'h00)
              + (blank_dly_bits_in[3] ? BLANK_B11 : 6'h00);
        blank_raw = dly_q[tap - 6'h01];
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            dly_q <= '1;
        end else if (clk_en_in) begin
            dly_q <= {dly_q[DLY_LEN-2:0], line_clock_gate_out};
        end
    end

    // Extra even-field hold on the first blank fall
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            composite_blank_out <= 1'h1;
            ext_q               <= '0;
            ext_pend_q          <= 1'h0;
        end else if (clk_en_in) begin
            if (frame_idle_flag_out && interlace_in && even_field_in) begin
                ext_pend_q <= 1'h1;
            end else if (composite_blank_out && !blank_raw && ext_q == '0) begin
                ext_pend_q <= 1'h0;
            end
            if (ext_q != '0) begin
                ext_q               <= ext_q - EXT_W'(1);
                composite_blank_out <= 1'h1;
            end else if (composite_blank_out && !blank_raw && ext_pend_q
                         && even_field_delay_in != '0) begin
                ext_q               <= {even_field_delay_in, 2'h0} - EXT_W'(1);
                composite_blank_out <= 1'h1;
            end else begin
                composite_blank_out <= blank_raw;
            end
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    serial_phase_a: assert property (free_serial_clock_n_out == !phase_q[1])
        else $error("serial clock out of step with phase");
    shift_gated_a: assert property (!vram_shift_clock_n_out |-> !line_clock_gate_out)
        else $error("shift clock pulsed during flyback");
    shift_edge_a: assert property ($fell(vram_shift_clock_n_out) |-> phase_q == PH_FALL
                                   && !free_serial_clock_n_out)
        else $error("shift fall not on serial fall");
    shift_rate_a: assert property (clk_en_in && latch_now && depth_sel_in == BPP_8
                                   ##1 clk_en_in [*3] ##1 clk_en_in && line_active_in
                                   && $past(line_active_in, 4)
                                   |=> !vram_shift_clock_n_out || phase_q != PH_FALL)
        else $error("8 bit shift rate wrong");
    lane_order_a: assert property (latch_now && port_mode_in == MODE_PALETTE
                                   && depth_sel_in == BPP_8 ##1 clk_en_in
                                   |=> pixel_index_out == ($past(pixel_lane_a_in, 2)
                                   & $past(mask_q)))
        else $error("lane A not shown first");
    gate_depth_a: assert property (clk_en_in && phase_d == PH_RISE
                                   |=> line_clock_gate_out == !$past(line_active_in))
        else $error("line gate not set on serial rise");
    even_hold_a: assert property (clk_en_in && ext_q != '0 |=> composite_blank_out)
        else $error("blank released during even field hold");
    mask_and_a: assert property (clk_en_in && !mask_wr_in && port_mode_in == MODE_PALETTE
                                 |=> (pixel_index_out & ~mask_q) == 8'h00)
        else $error("index not masked");
    direct_mode_a: assert property (clk_en_in && port_mode_in == MODE_DIRECT
                                    |=> pixel_colour_out == {$past(pixel_lane_a_in),
                                    $past(pixel_lane_b_in), $past(pixel_lane_c_in)})
        else $error("direct pixel not passed");
    pll_select_a: assert property (clk_en_in && port_mode_in == MODE_DIRECT
                                   |=> !use_pll_out)
        else $error("PLL chosen in mode 2");
    frame_flag_a: assert property (clk_en_in && phase_d == PH_RISE && !frame_active_in
                                   |=> frame_idle_flag_out)
        else $error("frame flag not raised in flyback");
    blank_follow_a: assert property (clk_en_in && dly_q == '1 && ext_q == '0
                                     |=> composite_blank_out)
        else $error("blank low while gate held high");

    line_start_c: cover property ($fell(line_clock_gate_out));
    shift_pulse_c: cover property ($fell(vram_shift_clock_n_out) && depth_sel_in == BPP_1);
    even_hold_c: cover property (ext_q != '0);
    direct_c: cover property (port_mode_in == MODE_DIRECT && pixel_valid_out);
endmodule : ppfs_pixel_port

// >>> hw/ppfs_pkg.sv
// Shared constants for the pixel port and frame strobes block
package ppfs_pkg;
    localparam int          LANE_W       = 8;
    localparam int          WORD_W       = 32;
    localparam int          COLOUR_W     = 24;
    localparam int          PAL_DEPTH    = 256;
    localparam int          DLY_LEN      = 40;
    localparam int          EXT_W        = 12;
    localparam logic [1:0]  PH_RISE      = 2'h0;
    localparam logic [1:0]  PH_FALL      = 2'h2;
    localparam logic [1:0]  PH_LAST      = 2'h3;
    localparam logic [1:0]  BPP_1        = 2'h0;
    localparam logic [1:0]  BPP_2        = 2'h1;
    localparam logic [1:0]  BPP_4        = 2'h2;
    localparam logic [1:0]  BPP_8        = 2'h3;
    localparam logic [5:0]  BLANK_BASE   = 6'h09;
    localparam logic [5:0]  BLANK_B8     = 6'h04;
    localparam logic [5:0]  BLANK_B9     = 6'h04;
    localparam logic [5:0]  BLANK_B10    = 6'h08;
    localparam logic [5:0]  BLANK_B11    = 6'h10;
    localparam logic        MODE_PALETTE = 1'h0;
    localparam logic        MODE_DIRECT  = 1'h1;
    localparam logic [7:0]  MASK_RESET   = 8'hFF;
endpackage : ppfs_pkg

// >>> test/ppfs_vram_model.sv
// Video RAM serial port model feeding the four pixel lanes
`timescale 1ns/100ps
module ppfs_vram_model
    import ppfs_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              sys_rst_in,
    // Shift clock from the block, ahead of the board inverter
    input  wire logic              shift_clock_n_in,
    // Serial data lanes
    output logic [LANE_W-1:0]      lane_a_out,
    output logic [LANE_W-1:0]      lane_b_out,
    output logic [LANE_W-1:0]      lane_c_out,
    output logic [LANE_W-1:0]      lane_d_out
);
    logic [3:0] word_q;
    logic       shift_n_q;
    // The inverter makes each falling edge the RAM's rising serial clock
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            word_q    <= 4'h0;
            shift_n_q <= 1'b1;
        end else begin
            shift_n_q <= shift_clock_n_in;
            if (shift_n_q && !shift_clock_n_in) begin
                word_q <= word_q + 4'h1;
            end
        end
    end
    assign lane_a_out = {word_q, 4'h1};
    assign lane_b_out = {word_q, 4'h6};
    assign lane_c_out = {word_q, 4'hA};
    assign lane_d_out = {word_q, 4'hF};
endmodule : ppfs_vram_model

// >>> test/tb.sv
// Self-checking bench for the pixel port and frame strobes block
`timescale 1ns/100ps
module tb;
    import ppfs_pkg::*;
    logic                clk = 1'b0, rst = 1'b1, mode = 1'b0, mwr = 1'b0;
    logic                pwr = 1'b0, prd = 1'b0, lact = 1'b0, fact = 1'b0;
    logic                wpll = 1'b0, boot = 1'b0, ser_n, sh_n, fidle, lgate, composite_blank;
    logic                upll, pval;
    logic                ilace = 1'b0, evenf = 1'b0;
    logic [EXT_W-3:0]    mdel = '0;
    logic [1:0]          depth = BPP_8;
    logic [3:0]          bdly = 4'h0;
    logic [7:0]          hbyte = 8'h00, paddr = 8'h00, mask_o, pidx;
    logic [COLOUR_W-1:0] pwd = '0, prdat, pcol, prev;
    logic [LANE_W-1:0]   la, lb, lc, ld;
    logic [7:0]          pix[$];
    int                  errors = 0, checked = 0, gaps = 0, n, d0, d1, d2, d3;
    always #10 clk = ~clk;
    ppfs_pixel_port dut (.sys_clk_in(clk), .sys_rst_in(rst), .clk_en_in(1'b1),
        .port_mode_in(mode), .depth_sel_in(depth), .blank_dly_bits_in(bdly),
        .interlace_in(ilace), .clk_wiring_pll_in(wpll), .boot_pll_bit_in(boot),
        .line_active_in(lact), .frame_active_in(fact), .even_field_in(evenf),
        .even_field_delay_in(mdel), .pixel_lane_a_in(la), .pixel_lane_b_in(lb),
        .pixel_lane_c_in(lc), .pixel_lane_d_in(ld), .mask_wr_in(mwr),
        .host_bus_low_byte_in(hbyte), .pixel_address_mask_out(mask_o), .pal_wr_in(pwr),
        .pal_rd_in(prd), .pal_addr_in(paddr), .pal_wdata_in(pwd), .pal_rdata_out(prdat),
        .free_serial_clock_n_out(ser_n), .vram_shift_clock_n_out(sh_n),
        .frame_idle_flag_out(fidle), .line_clock_gate_out(lgate),
        .composite_blank_out(composite_blank), .use_pll_out(upll), .pixel_index_out(pidx),
        .pixel_colour_out(pcol), .pixel_valid_out(pval));
    ppfs_vram_model vram (.sys_clk_in(clk), .sys_rst_in(rst), .shift_clock_n_in(sh_n),
        .lane_a_out(la), .lane_b_out(lb), .lane_c_out(lc), .lane_d_out(ld));
    always @(negedge clk) begin
        if (pval === 1'b1 && pix.size() < 64) pix.push_back(pidx);
        else if (pix.size() > 0 && pix.size() < 64) gaps++;
    end
    task automatic summarize();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp24(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp24
    task automatic cmpn(input int got, input int exp);
        cmp24(got[23:0], exp[23:0]);
    endtask : cmpn
    function automatic logic sig(input int w);
        case (w)
            0: sig = fidle;
            1: sig = composite_blank;
            2: sig = sh_n;
            3: sig = ~ser_n;
            default: sig = ~fidle;
        endcase
    endfunction : sig
    // Cycles until the chosen signal goes from 1 to 0, with a bound
    task automatic wait_ev(input int w, output int cnt);
        logic p;
        p = sig(w);
        for (cnt = 1; cnt <= 300; cnt++) begin
            @(posedge clk);
            #1;
            if (p === 1'b1 && sig(w) === 1'b0) return;
            p = sig(w);
        end
        errors++;
        summarize();
    endtask : wait_ev
    task automatic start(input logic [1:0] dsel, input logic m, input logic [3:0] b);
        @(posedge clk);
        rst <= 1'b1;
        lact <= 1'b0;
        fact <= 1'b0;
        depth <= dsel;
        mode <= m;
        bdly <= b;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        pix.delete();
        gaps = 0;
    endtask : start
    task automatic host(input logic [1:0] op, input logic [7:0] a, input logic [23:0] v);
        @(posedge clk);
        {prd, pwr, mwr} <= {op == 2'h2, op == 2'h1, op == 2'h0};
        paddr <= a;
        hbyte <= a;
        pwd <= v;
        @(posedge clk);
        {prd, pwr, mwr} <= 3'h0;
        @(posedge clk);
        #1;
    endtask : host
    function automatic logic [7:0] expix(input int bpp, input int i, input logic [7:0] m);
        logic [3:0]  k;
        logic [31:0] w;
        k = 4'(i / (32 / bpp));
        w = {k, 4'hF, k, 4'hA, k, 4'h6, k, 4'h1} >> ((i % (32 / bpp)) * bpp);
        return w[7:0] & 8'((1 << bpp) - 1) & m;
    endfunction : expix
    task automatic stream(input logic [1:0] dsel, input int bpp, input logic [7:0] m);
        start(dsel, MODE_PALETTE, 4'h0);
        host(2'h0, m, '0);
        cmp8(mask_o, m);
        lact <= 1'b1;
        fact <= 1'b1;
        wait_ev(0, n);
        cmp8({ser_n, lgate}, 8'h02);
        wait_ev(2, n);
        cmpn(n, 2);
        wait_ev(2, n);
        cmpn(n, 32 / bpp);
        for (n = 0; n < 3000 && pix.size() < 64; n++) @(posedge clk);
        cmpn(pix.size(), 64);
        if (pix.size() < 64) summarize();
        for (int i = 0; i < pix.size(); i++) cmp8(pix[i], expix(bpp, i, m));
        cmpn(gaps, 0);
        lact <= 1'b0;
        fact <= 1'b0;
        wait_ev(4, n);
        cmp8({7'h0, lgate}, 8'h01);
        wait_ev(3, n);
        wait_ev(3, n);
        cmpn(n, 4);
        for (n = 0; n < 40 && sh_n === 1'b1; n++) @(posedge clk);
        cmpn(n, 40);
    endtask : stream
    task automatic blank_delay(input logic [3:0] b, output int dly);
        start(BPP_8, MODE_PALETTE, b);
        lact <= 1'b1;
        fact <= 1'b1;
        wait_ev(0, n);
        wait_ev(1, dly);
    endtask : blank_delay
    initial begin
        repeat (3) @(posedge clk);
        #1;
        cmp8({ser_n, sh_n, fidle, lgate, composite_blank, upll, pval, 1'b0}, 8'h78);
        cmp8(mask_o, MASK_RESET);
        @(posedge clk);
        rst <= 1'b0;
        host(2'h1, 8'h00, 24'hA5C3E1);
        host(2'h1, 8'hFF, 24'h1234EF);
        host(2'h2, 8'h00, '0);
        cmp24(prdat, 24'hA5C3E1);
        host(2'h2, 8'hFF, '0);
        cmp24(prdat, 24'h1234EF);
        stream(BPP_8, 8, 8'h3C);
        stream(BPP_4, 4, 8'hFF);
        stream(BPP_2, 2, 8'hFE);
        stream(BPP_1, 1, 8'hFF);
        blank_delay(4'h0, d0);
        blank_delay(4'h1, d1);
        blank_delay(4'hE, d2);
        cmpn(d0 - d1, 4);
        cmpn(d2 - d0, 28);
        ilace <= 1'b1;
        evenf <= 1'b1;
        mdel <= 10'h003;
        blank_delay(4'h0, d3);
        cmpn(d3 - d0, 12);
        wpll <= 1'b1;
        boot <= 1'b1;
        start(BPP_8, MODE_DIRECT, 4'h0);
        host(2'h0, 8'h00, '0);
        cmp8({7'h0, upll}, 8'h00);
        prev = {la, lb, lc};
        @(posedge clk);
        #1;
        cmp24(pcol, prev);
        mode <= MODE_PALETTE;
        repeat (2) @(posedge clk);
        #1;
        cmp8({7'h0, upll}, 8'h01);
        summarize();
    end
endmodule : tb
